// file: pkg/mft_pkg.sv
// constants, types and register map of the timer pin recovery block
// assumes a single clock domain and a plain register port driven by software
`default_nettype none

package mft_pkg;

    localparam int          NUM_CH      = 5;
    localparam int          CNT_W       = 16;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;

    // register byte addresses
    localparam logic [7:0]  ADDR_START  = 8'h00;
    localparam logic [7:0]  ADDR_OUT_EN = 8'h04;
    localparam logic [7:0]  ADDR_OUT_CT = 8'h08;
    localparam logic [7:0]  ADDR_PINFN  = 8'h0C;
    localparam logic [7:0]  ADDR_PORTDR = 8'h10;
    localparam logic [7:0]  ADDR_PORTEN = 8'h14;
    localparam logic [7:0]  ADDR_LEVELS = 8'h18;
    localparam logic [7:0]  ADDR_CH_BASE = 8'h20;
    localparam logic [3:0]  CH_STRIDE_SH = 4'h4;
    localparam logic [3:0]  OFF_MODE    = 4'h0;
    localparam logic [3:0]  OFF_IOCTL   = 4'h4;
    localparam logic [3:0]  OFF_CMP     = 4'h8;
    localparam logic [3:0]  OFF_CNT     = 4'hC;

    // first channel gated by the output master enable
    localparam int          FIRST_GATED_CH = 3;
    // io control field positions
    localparam int          IOC_INIT_A  = 0;
    localparam int          IOC_MATCH_A = 1;
    localparam int          IOC_INIT_B  = 2;
    localparam int          IOC_MATCH_B = 3;
    localparam int          IOC_EN_A    = 4;
    localparam int          IOC_EN_B    = 5;
    // output control field positions
    localparam int          OCR_LEVEL   = 0;
    localparam int          OCR_CYCLIC  = 1;

    localparam logic [5:0]  IOC_RESET   = 6'h00;
    localparam logic [1:0]  OCR_RESET   = 2'h0;
    localparam logic [1:0]  OUT_EN_RESET = 2'h0;
    localparam logic [15:0] CMP_RESET   = 16'hFFFF;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_PWM_ONE,
        MODE_PWM_TWO,
        MODE_PHASE,
        MODE_COMPL,
        MODE_RSYNC
    } mft_mode_e;

    typedef struct packed {
        logic match_b_en;
        logic match_a_en;
        logic match_b;
        logic init_b;
        logic match_a;
        logic init_a;
    } mft_ioc_s;

    typedef struct packed {
        mft_mode_e        mode;
        mft_ioc_s         ioc;
        logic [CNT_W-1:0] cmp;
        logic             run;
        logic             out_ok;
        logic             ocr_level;
    } mft_ch_cfg_s;

    typedef struct packed {
        logic             ioc_wr;
        logic             mode_wr;
    } mft_ch_evt_s;

endpackage : mft_pkg

`default_nettype wire

// file: rtl/mft_channel.sv
// one timer channel: counter, compare match and the two output levels
// assumes its configuration and one-cycle write events come from mft_top
`default_nettype none

module mft_channel (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire mft_pkg::mft_ch_cfg_s      cfg,
    input  wire mft_pkg::mft_ch_evt_s      evt,
    output logic [mft_pkg::CNT_W-1:0]      cnt_r,
    output logic                           lvl_a_r,
    output logic                           lvl_b_r
);

    logic [mft_pkg::CNT_W-1:0] cnt_nxt;
    logic                      lvl_a_nxt;
    logic                      lvl_b_nxt;
    logic                      hit;
    logic                      pwm_two;

    always_comb begin
        pwm_two   = (cfg.mode == mft_pkg::MODE_PWM_TWO);
        hit       = cfg.run && (cnt_r == cfg.cmp);
        cnt_nxt   = cnt_r;
        lvl_a_nxt = lvl_a_r;
        lvl_b_nxt = lvl_b_r;
        if (cfg.run) begin
            if (pwm_two && hit) begin
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
        if (hit && cfg.ioc.match_a_en && !pwm_two) begin
            lvl_a_nxt = cfg.ioc.match_a;
        end
        if (hit && cfg.ioc.match_b_en && cfg.mode != mft_pkg::MODE_PWM_ONE) begin
            lvl_b_nxt = cfg.ioc.match_b;
        end
        if (evt.ioc_wr && cfg.out_ok) begin
            if (!pwm_two) begin
                lvl_a_nxt = cfg.ioc.init_a;
            end
            if (cfg.mode != mft_pkg::MODE_PWM_ONE) begin
                lvl_b_nxt = cfg.ioc.init_b;
            end
        end
        // entering a level-from-output-control mode takes that level
        if (evt.mode_wr && (cfg.mode == mft_pkg::MODE_COMPL
                            || cfg.mode == mft_pkg::MODE_RSYNC)) begin
            lvl_a_nxt = cfg.ocr_level;
            lvl_b_nxt = cfg.ocr_level;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r   <= '0;
            lvl_a_r <= 1'b0;
            lvl_b_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            lvl_a_r <= lvl_a_nxt;
            lvl_b_r <= lvl_b_nxt;
        end
    end

endmodule : mft_channel

`default_nettype wire

// file: rtl/mft_top.sv
// top of the multi-function timer pin recovery block: registers, channels, pin mux
// assumes one 125 MHz clock, synchronous reset and a plain register port
//
// What this block does
// - after reset the timer outputs are low and every pin stays undriven until routed.
// - in pwm mode one an io control write does not initialise the b-side pin.
// - in pwm mode two an io control write does not initialise the cycle register pin.
// - pwm mode two is accepted only on channels 0 to 2.
// - phase counting mode is accepted only on channels 1 and 2.
// - after a high initial level with low-on-match, a compare match drives the output low.
// - in pwm mode two the a-side register is the cycle register and its pin is excluded.
//
// Chosen here: the placing of the registers and the plain strobed port.
`default_nettype none

module mft_top (
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire logic [mft_pkg::ADDR_W-1:0]   addr,
    input  wire logic [mft_pkg::DATA_W-1:0]   wr_data,
    input  wire logic                         wr_en,
    input  wire logic                         rd_en,
    output logic      [mft_pkg::DATA_W-1:0]   rd_data_r,
    output logic      [2*mft_pkg::NUM_CH-1:0] pin_out_r,
    output logic      [2*mft_pkg::NUM_CH-1:0] pin_oe_r
);

    localparam int NCH = mft_pkg::NUM_CH;
    localparam int NP  = 2 * mft_pkg::NUM_CH;

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [NCH-1:0]         start_r,   start_nxt;
    logic [1:0]             out_en_r,  out_en_nxt;
    logic [1:0]             ocr_r,     ocr_nxt;
    logic [NCH-1:0]         pinfn_r,   pinfn_nxt;
    logic [NP-1:0]          portdr_r,  portdr_nxt;
    logic [NP-1:0]          porten_r,  porten_nxt;
    mft_pkg::mft_mode_e     mode_r     [NCH];
    mft_pkg::mft_mode_e     mode_nxt   [NCH];
    mft_pkg::mft_ioc_s      ioc_r      [NCH];
    mft_pkg::mft_ioc_s      ioc_nxt    [NCH];
    logic [mft_pkg::CNT_W-1:0] cmp_r   [NCH];
    logic [mft_pkg::CNT_W-1:0] cmp_nxt [NCH];
    mft_pkg::mft_ch_evt_s   evt_r      [NCH];
    mft_pkg::mft_ch_evt_s   evt_nxt    [NCH];
    logic [mft_pkg::DATA_W-1:0] rd_data_nxt;

    logic [mft_pkg::CNT_W-1:0] cnt_w   [NCH];
    logic [NCH-1:0]         lvl_a_w;
    logic [NCH-1:0]         lvl_b_w;
    logic [NP-1:0]          lvl_w;
    logic [NCH-1:0]         out_ok_w;

    logic                   ch_sel;
    logic [2:0]             ch_idx;
    logic [3:0]             ch_off;

    // per-channel register window: base + channel * 16 + offset
    always_comb begin
        ch_sel = (addr >= mft_pkg::ADDR_CH_BASE)
                 && (addr < mft_pkg::ADDR_CH_BASE + 8'(NCH << mft_pkg::CH_STRIDE_SH));
        ch_idx = 3'((addr - mft_pkg::ADDR_CH_BASE) >> mft_pkg::CH_STRIDE_SH);
        ch_off = addr[3:0];
    end

    // legal mode for a channel; illegal writes keep the old mode
    function automatic logic mode_ok(input logic [2:0] code, input int ch);
        logic ok;
        ok = 1'b1;
        unique case (code)
            3'(mft_pkg::MODE_NORMAL), 3'(mft_pkg::MODE_PWM_ONE): ok = 1'b1;
            // pwm two on 0 to 2
            3'(mft_pkg::MODE_PWM_TWO): ok = (ch <= 2);
            3'(mft_pkg::MODE_PHASE): ok = (ch == 1) || (ch == 2);
            3'(mft_pkg::MODE_COMPL), 3'(mft_pkg::MODE_RSYNC):
                ok = (ch >= mft_pkg::FIRST_GATED_CH);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : mode_ok

    always_comb begin
        start_nxt  = start_r;
        out_en_nxt = out_en_r;
        ocr_nxt    = ocr_r;
        pinfn_nxt  = pinfn_r;
        portdr_nxt = portdr_r;
        porten_nxt = porten_r;
        for (int i = 0; i < NCH; i++) begin
            mode_nxt[i] = mode_r[i];
            ioc_nxt[i]  = ioc_r[i];
            cmp_nxt[i]  = cmp_r[i];
            evt_nxt[i]  = '0;
        end
        if (wr_en) begin
            unique case (addr)
                mft_pkg::ADDR_START:  start_nxt  = wr_data[NCH-1:0];
                mft_pkg::ADDR_OUT_EN: out_en_nxt = wr_data[1:0];
                mft_pkg::ADDR_OUT_CT: ocr_nxt    = wr_data[1:0];
                mft_pkg::ADDR_PINFN:  pinfn_nxt  = wr_data[NCH-1:0];
                mft_pkg::ADDR_PORTDR: portdr_nxt = wr_data[NP-1:0];
                mft_pkg::ADDR_PORTEN: porten_nxt = wr_data[NP-1:0];
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (ch_sel && ch_idx == 3'(i)) begin
                            if (ch_off == mft_pkg::OFF_MODE && mode_ok(wr_data[2:0], i)) begin
                                mode_nxt[i]        = mft_pkg::mft_mode_e'(wr_data[2:0]);
                                evt_nxt[i].mode_wr = 1'b1;
                            end
                            if (ch_off == mft_pkg::OFF_IOCTL) begin
                                ioc_nxt[i]        = mft_pkg::mft_ioc_s'(wr_data[5:0]);
                                evt_nxt[i].ioc_wr = 1'b1;
                            end
                            if (ch_off == mft_pkg::OFF_CMP) begin
                                cmp_nxt[i] = wr_data[mft_pkg::CNT_W-1:0];
                            end
                        end
                    end
                end
            endcase
        end
    end

    // read answer lands in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        rd_data_nxt = '0;
        if (rd_en) begin
            unique case (addr)
                mft_pkg::ADDR_START:  rd_data_nxt = 32'(start_r);
                mft_pkg::ADDR_OUT_EN: rd_data_nxt = 32'(out_en_r);
                mft_pkg::ADDR_OUT_CT: rd_data_nxt = 32'(ocr_r);
                mft_pkg::ADDR_PINFN:  rd_data_nxt = 32'(pinfn_r);
                mft_pkg::ADDR_PORTDR: rd_data_nxt = 32'(portdr_r);
                mft_pkg::ADDR_PORTEN: rd_data_nxt = 32'(porten_r);
                mft_pkg::ADDR_LEVELS: rd_data_nxt = 32'(lvl_w);
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (ch_sel && ch_idx == 3'(i)) begin
                            unique case (ch_off)
                                mft_pkg::OFF_MODE:  rd_data_nxt = 32'(mode_r[i]);
                                mft_pkg::OFF_IOCTL: rd_data_nxt = 32'(ioc_r[i]);
                                mft_pkg::OFF_CMP:   rd_data_nxt = 32'(cmp_r[i]);
                                mft_pkg::OFF_CNT:   rd_data_nxt = 32'(cnt_w[i]);
                                default:            rd_data_nxt = '0;
                            endcase
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            start_r   <= '0;
            out_en_r  <= mft_pkg::OUT_EN_RESET;
            ocr_r     <= mft_pkg::OCR_RESET;
            pinfn_r   <= '0;
            portdr_r  <= '0;
            porten_r  <= '0;
            rd_data_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                mode_r[i] <= mft_pkg::MODE_NORMAL;
                ioc_r[i]  <= mft_pkg::mft_ioc_s'(mft_pkg::IOC_RESET);
                cmp_r[i]  <= mft_pkg::CMP_RESET;
                evt_r[i]  <= '0;
            end
        end else begin
            start_r   <= start_nxt;
            out_en_r  <= out_en_nxt;
            ocr_r     <= ocr_nxt;
            pinfn_r   <= pinfn_nxt;
            portdr_r  <= portdr_nxt;
            porten_r  <= porten_nxt;
            rd_data_r <= rd_data_nxt;
            for (int i = 0; i < NCH; i++) begin
                mode_r[i] <= mode_nxt[i];
                ioc_r[i]  <= ioc_nxt[i];
                cmp_r[i]  <= cmp_nxt[i];
                evt_r[i]  <= evt_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channels; events are registered so each channel sees the new settings

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        mft_pkg::mft_ch_cfg_s cfg;
        // channels 3 and 4 need master enable
        // split by generate so the ungated channels never form an out-of-range index
        if (g < mft_pkg::FIRST_GATED_CH) begin : g_free
            assign out_ok_w[g] = 1'b1;
        end else begin : g_gated
            assign out_ok_w[g] = out_en_r[g - mft_pkg::FIRST_GATED_CH];
        end
        assign cfg.mode      = mode_r[g];
        assign cfg.ioc       = ioc_r[g];
        assign cfg.cmp       = cmp_r[g];
        assign cfg.run       = start_r[g];
        assign cfg.out_ok    = out_ok_w[g];
        assign cfg.ocr_level = ocr_r[mft_pkg::OCR_LEVEL];
        assign lvl_w[2*g]    = lvl_a_w[g];
        assign lvl_w[2*g+1]  = lvl_b_w[g];

        mft_channel mft_channel_inst (
            .clock   (clock),
            .rst     (rst),
            .cfg     (cfg),
            .evt     (evt_r[g]),
            .cnt_r   (cnt_w[g]),
            .lvl_a_r (lvl_a_w[g]),
            .lvl_b_r (lvl_b_w[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin function: timer output, port output, or undriven

    logic [NP-1:0] pin_out_nxt;
    logic [NP-1:0] pin_oe_nxt;

    always_comb begin
        for (int p = 0; p < NP; p++) begin
            pin_out_nxt[p] = 1'b0;
            pin_oe_nxt[p]  = 1'b0;
            if (pinfn_r[p/2]) begin
                pin_out_nxt[p] = lvl_w[p];
                pin_oe_nxt[p]  = out_ok_w[p/2];
            end else if (porten_r[p]) begin
                pin_out_nxt[p] = portdr_r[p];
                pin_oe_nxt[p]  = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_out_r <= '0;
            pin_oe_r  <= '0;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

endmodule : mft_top

`default_nettype wire

// file: tb/mft_load_model.sv
// external loads hanging on the ten timer pins
// assumes a low active load and no pull resistor on the pins
`default_nettype none

module mft_load_model (
    input  wire logic       clock,
    input  wire logic [9:0] pin_out,
    input  wire logic [9:0] pin_oe,
    output logic      [9:0] pad,
    output logic      [9:0] load_on
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] last_r = 10'h000;

    // an undriven pin shows the inverse of its last driven level, so a stale level never
    // passes for a driven one; unknown enables before reset are not taken in
    always_ff @(posedge clock) begin
        if (!$isunknown(pin_oe)) begin
            last_r <= (pin_oe & pin_out) | (~pin_oe & last_r);
        end
    end
    assign pad = (pin_oe & pin_out) | (~pin_oe & ~last_r);
    assign load_on = pin_oe & ~pin_out;
endmodule : mft_load_model

`default_nettype wire

// file: tb/mft_top_chk.sv
// port assertions for the timer pin block
// assumes it is bound to mft_top and sees only that module's ports
`default_nettype none

module mft_top_chk (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rd_data_r,
    input wire logic [9:0]  pin_out_r,
    input wire logic [9:0]  pin_oe_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] run_r;
    logic [4:0] run_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the start bits, seen from the write port only
    always_comb begin
        run_nxt = run_r;
        if (wr_en && addr == 8'h00) begin
            run_nxt = wr_data[4:0];
        end
    end
    always_ff @(posedge clock) begin
        run_r <= rst ? 5'h00 : run_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_rd_idle_zero: assert property (!rd_en |=> rd_data_r == 32'h0000_0000)
        else $error("read data not zero after idle cycle");
    a_unmapped_zero: assert property (rd_en && addr == 8'hFC |=> rd_data_r == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> pin_oe_r == 10'h000 && pin_out_r == 10'h000)
        else $error("pins active after reset");
    a_port_drive: assert property (wr_en && addr == 8'h14 && wr_data[1:0] == 2'b11
        |-> ##[1:3] pin_oe_r[1:0] == 2'b11)
        else $error("port drive not applied");
    a_start_readback: assert property (wr_en && addr == 8'h00 ##1 rd_en && addr == 8'h00
        |=> rd_data_r[4:0] == $past(wr_data[4:0], 2))
        else $error("start bits not stored");
    a_pwm_two_refused: assert property (wr_en && addr == 8'h50 && wr_data[2:0] == 3'h2
        ##1 rd_en && addr == 8'h50 |=> rd_data_r[2:0] != 3'h2)
        else $error("pwm two accepted on channel three");
    a_phase_refused: assert property (wr_en && wr_data[2:0] == 3'h3
        && (addr == 8'h20 || addr == 8'h50 || addr == 8'h60)
        ##1 rd_en && addr == $past(addr) |=> rd_data_r[2:0] != 3'h3)
        else $error("phase counting accepted on wrong channel");
    // the second read answers one cycle after the first, so both stand at adjacent edges
    a_halt_hold: assert property (rd_en && addr == 8'h2C && !run_r[0]
        && !$past(run_r[0]) ##1 rd_en && addr == 8'h2C |=> rd_data_r == $past(rd_data_r))
        else $error("halted counter moved");
    a_run_count: assert property (rd_en && addr == 8'h2C && run_r[0]
        && $past(run_r[0], 3) ##1 rd_en && addr == 8'h2C
        |=> rd_data_r == $past(rd_data_r) + 32'h0000_0001)
        else $error("running counter not one per clock");

    c_port_drive: cover property (wr_en && addr == 8'h14 && wr_data[1:0] == 2'b11);
    c_halt_pair: cover property (rd_en && addr == 8'h2C && !run_r[0] ##1 rd_en && addr == 8'h2C);
    c_mode_refuse: cover property (wr_en && addr == 8'h50 && wr_data[2:0] == 3'h2);
endmodule : mft_top_chk

bind mft_top mft_top_chk mft_top_chk_inst (.clock(clock), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_r(rd_data_r),
    .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r));

`default_nettype wire

// file: tb/mft_top_tb.sv
// self-checking bench for the timer pin block
// assumes mft_top with its checker bound and the load model on its pins
`default_nettype none

module mft_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock   = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wr_data = 32'h0000_0000;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic [31:0] rd_data_r;
    logic [9:0]  pin_out_r;
    logic [9:0]  pin_oe_r;
    logic [9:0]  pad;
    logic [9:0]  load_on;
    logic [31:0] q;
    logic [31:0] q2;
    int          bad_count  = 0;
    int          num_checks = 0;

    always #4 clock = ~clock;

    mft_top mft_top_inst (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data_r(rd_data_r), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r));
    mft_load_model mft_load_model_inst (.clock(clock), .pin_out(pin_out_r), .pin_oe(pin_oe_r),
        .pad(pad), .load_on(load_on));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr    <= a;
        wr_data <= d;
        wr_en   <= w;
        rd_en   <= !w;
    endtask : put
    task automatic idle();
        @(posedge clock);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        #1;
    endtask : idle
    task automatic gap(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : gap
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        put(1'b1, a, d);
        idle();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge clock);
        put(1'b0, a, 32'h0000_0000);
        idle();
        r = rd_data_r;
    endtask : rd
    // an access followed with no gap by a read of the same place
    task automatic two(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r1, output logic [31:0] r2);
        @(posedge clock);
        put(w, a, d);
        @(posedge clock);
        put(1'b0, a, 32'h0000_0000);
        #1;
        r1 = rd_data_r;
        idle();
        r2 = rd_data_r;
    endtask : two
    task automatic wait_pin(input int b, input logic v);
        for (int i = 0; i < 200 && pin_out_r[b] !== v; i++) begin
            @(posedge clock);
        end
        #1;
        if (pin_out_r[b] !== v) begin
            chk(32'(pin_out_r[b]), 32'(v));
            test_done();
        end
    endtask : wait_pin
    function automatic logic ok(input int c, input int m);
        return !((m == 2 && c > 2) || (m == 3 && (c < 1 || c > 2)) || (m > 3 && c < 3));
    endfunction : ok

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        chk(32'({pin_oe_r, pin_out_r}), 32'h0000_0000);
        rd(8'h18, q);
        chk(q, 32'h0000_0000);
        rd(8'h28, q);
        chk(q, 32'h0000_FFFF);
        wr(8'hFC, 32'h0000_FFFF);
        wr(8'h18, 32'h0000_03FF);
        rd(8'hFC, q);
        chk(q, 32'h0000_0000);
        rd(8'h18, q);
        chk(q, 32'h0000_0000);
        $display("test reset done");

        // pwm one on channel 0, error, then restart in normal mode
        wr(8'h20, 32'h0000_0001);
        wr(8'h24, 32'h0000_0035);
        rd(8'h18, q);
        chk(q, 32'h0000_0001);
        wr(8'h28, 32'h0000_0014);
        wr(8'h0C, 32'h0000_0001);
        gap(3);
        chk(32'(pad[1:0]), 32'h0000_0001);
        two(1'b1, 8'h00, 32'h0000_0001, q, q2);
        chk(q2, 32'h0000_0001);
        wait_pin(0, 1'b0);
        rd(8'h18, q);
        chk(q, 32'h0000_0000);
        wr(8'h10, 32'h0000_0003);
        wr(8'h14, 32'h0000_0003);
        wr(8'h0C, 32'h0000_0000);
        gap(3);
        chk(32'({pin_oe_r[1:0], pad[1:0]}), 32'h0000_000F);
        chk(32'(load_on), 32'h0000_0000);
        wr(8'h00, 32'h0000_0000);
        gap(3);
        two(1'b0, 8'h2C, 32'h0000_0000, q, q2);
        chk(q2, q);
        rd(8'h18, q);
        chk(q, 32'h0000_0000);
        wr(8'h20, 32'h0000_0000);
        wr(8'h24, 32'h0000_0035);
        rd(8'h18, q);
        chk(q, 32'h0000_0003);
        wr(8'h0C, 32'h0000_0001);
        wr(8'h00, 32'h0000_0001);
        gap(3);
        chk(32'(pad[1:0]), 32'h0000_0003);
        two(1'b0, 8'h2C, 32'h0000_0000, q, q2);
        chk(q2, q + 32'h0000_0001);
        wr(8'h00, 32'h0000_0000);
        $display("test pwm one recovery done");

        // pwm two on channel 1, then same-mode restart
        wr(8'h30, 32'h0000_0002);
        wr(8'h34, 32'h0000_0035);
        rd(8'h18, q);
        chk(q, 32'h0000_000B);
        wr(8'h34, 32'h0000_0031);
        rd(8'h18, q);
        chk(q, 32'h0000_0003);
        $display("test pwm two done");

        // channel 3 gated by master enable, then complementary and reset-sync entry
        wr(8'h54, 32'h0000_0035);
        rd(8'h18, q);
        chk(q, 32'h0000_0003);
        wr(8'h04, 32'h0000_0001);
        wr(8'h54, 32'h0000_0035);
        rd(8'h18, q);
        chk(q, 32'h0000_00C3);
        wr(8'h54, 32'h0000_0000);
        wr(8'h04, 32'h0000_0000);
        two(1'b1, 8'h08, 32'h0000_0003, q, q2);
        chk(q2, 32'h0000_0003);
        wr(8'h50, 32'h0000_0004);
        rd(8'h18, q);
        chk(q, 32'h0000_00C3);
        wr(8'h04, 32'h0000_0001);
        wr(8'h0C, 32'h0000_0009);
        gap(3);
        chk(32'({pin_oe_r[7:6], pad[7:6]}), 32'h0000_000F);
        wr(8'h04, 32'h0000_0000);
        gap(3);
        chk(32'({pin_oe_r[7:6], pad[7:6]}), 32'h0000_0000);
        wr(8'h08, 32'h0000_0000);
        wr(8'h50, 32'h0000_0005);
        rd(8'h18, q);
        chk(q, 32'h0000_0003);
        wr(8'h04, 32'h0000_0001);
        $display("test channel three done");

        // every mode code on every channel
        for (int c = 0; c < 5; c++) begin
            for (int m = 0; m < 6; m++) begin
                wr(8'h20 + 8'(16 * c), 32'h0000_0000);
                two(1'b1, 8'h20 + 8'(16 * c), 32'(m), q, q2);
                chk(q2, ok(c, m) ? 32'(m) : 32'h0000_0000);
            end
        end
        $display("test mode table done");
        test_done();
    end
endmodule : mft_top_tb

`default_nettype wire
